// ### dv/mwt_stage_model.sv
// power stage model returning regulator results and coil status
module mwt_stage_model #(
  parameter logic [7:0] DUTY = 8'hc8,
  parameter logic [8:0] OFFS = 9'h1f6,
  parameter logic [7:0] OFSA = 8'h24,
  parameter logic [7:0] GRAD = 8'h0e
) (
  // scaled coil demands
  input wire logic [8:0] phaseAScaled,
  input wire logic [8:0] phaseBScaled,
  // regulator results
  output logic [7:0]     dutyCycleActual,
  output logic [8:0]     pwmAutoOffset,
  output logic [7:0]     pwmOfsAuto,
  output logic [7:0]     pwmGradAuto,
  output logic [31:0]    driverStatus
);
  timeunit 1ns;
  timeprecision 1ps;
  // a settled regulator: fixed results keep expectations exact
  assign dutyCycleActual = DUTY;
  assign pwmAutoOffset   = OFFS;
  assign pwmOfsAuto      = OFSA;
  assign pwmGradAuto     = GRAD;
  assign driverStatus    = {7'h00, phaseAScaled, 7'h00, phaseBScaled};
endmodule // mwt_stage_model

// ### dv/mwt_wave_driver_asserts.sv
// port checker for the microstep wave table driver
module mwt_wave_driver_asserts
  import mwt_pkg::*;
(
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // apb slave side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [8:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  // step handshake
  input wire logic        stepReq,
  input wire logic        stepDir,
  input wire logic        stepReady,
  // commutation
  input wire logic        commutation_enable_pin,
  input wire logic        commutationVelocityReached,
  input wire logic        commutationActive,
  input wire logic [9:0]  commutationOnTimeCycles,
  input wire logic [11:0] stepLossOnTimeCycles,
  input wire logic        stepLossDetectEn,
  // configuration and currents
  input wire logic [31:0] chopperConfig,
  input wire logic [31:0] voltagePwmConfig,
  input wire logic [9:0]  microstepPosition,
  input wire logic [8:0]  phaseACurrent,
  input wire logic [8:0]  phaseBCurrent
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        wrAcc;
  logic [31:0] wdat_q;
  logic [7:0]  st0_q;
  logic [7:0]  st256_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  assign wrAcc = psel && penable && pwrite && !pslverr;
  always_ff @(posedge ref_clk) begin
    wdat_q <= pwdata;
  end
  // shadow of the start currents, only lanes 0 and 2 carry fields
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st0_q   <= ENTRY0_START_RESET;
      st256_q <= ENTRY256_START_RESET;
    end else if (wrAcc && paddr == 9'h1a4) begin
      if (pstrb[0]) st0_q <= pwdata[7:0];
      if (pstrb[2]) st256_q <= pwdata[23:16];
    end
  end
  a_cfg_reset: assert property ($rose(rst_n) |-> chopperConfig == CHOPPER_CONFIG_RESET
    && voltagePwmConfig == PWM_CONFIG_RESET) else $error("config reset value wrong");
  a_start_reset: assert property ($rose(rst_n) |-> phaseBCurrent == 9'h000
    && phaseACurrent == {1'b0, ENTRY256_START_RESET} && microstepPosition == 10'h000)
    else $error("current reset value wrong");
  a_loss_units: assert property (stepLossDetectEn == (stepLossOnTimeCycles != 12'h000)
    && stepLossOnTimeCycles[3:0] == 4'h0) else $error("step loss limit inconsistent");
  a_comm_write: assert property (wrAcc && paddr == 9'h1b8 && pstrb == 4'hf |=>
    commutationOnTimeCycles == wdat_q[9:0] && stepLossOnTimeCycles == {wdat_q[23:16], 4'h0})
    else $error("commutation fields wrong");
  a_chop_write: assert property (wrAcc && paddr == 9'h1b0 && pstrb == 4'hf |=>
    chopperConfig == wdat_q) else $error("chopper config not written");
  a_step_pos: assert property (stepReq && stepReady |=>
    microstepPosition == $past(microstepPosition) + ($past(stepDir) ? 10'h3ff : 10'h001))
    else $error("position step wrong");
  a_step_refuse: assert property (stepReq && !stepReady |=> $stable(microstepPosition))
    else $error("refused step moved position");
  a_zero_load: assert property (stepReq && stepReady
    && microstepPosition == (stepDir ? 10'h001 : 10'h3ff)
    |=> phaseBCurrent == {1'b0, st0_q} && phaseACurrent == {1'b0, st256_q})
    else $error("start currents not loaded at zero");
  a_vel_active: assert property (commutationVelocityReached |=> commutationActive)
    else $error("velocity enable ignored");
  a_pin_active: assert property ($rose(commutation_enable_pin) |-> ##[3:6] commutationActive)
    else $error("pin enable ignored");
  a_bad_addr: assert property (psel && !penable && (paddr[1:0] != 2'b00
    || paddr[8:2] < IDX_WAVE_TABLE_0 || paddr[8:2] > IDX_PWM_AUTOTUNE) |=> pslverr)
    else $error("bad address not refused");
  a_one_wait: assert property (psel && penable |-> pready) else $error("access phase stalled");
endmodule // mwt_wave_driver_asserts

bind mwt_wave_driver mwt_wave_driver_asserts u_asserts (
  .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .stepReq(stepReq), .stepDir(stepDir), .stepReady(stepReady),
  .commutation_enable_pin(commutation_enable_pin),
  .commutationVelocityReached(commutationVelocityReached),
  .commutationActive(commutationActive), .commutationOnTimeCycles(commutationOnTimeCycles),
  .stepLossOnTimeCycles(stepLossOnTimeCycles), .stepLossDetectEn(stepLossDetectEn),
  .chopperConfig(chopperConfig), .voltagePwmConfig(voltagePwmConfig),
  .microstepPosition(microstepPosition), .phaseACurrent(phaseACurrent),
  .phaseBCurrent(phaseBCurrent));

// ### dv/mwt_wave_driver_tb_top.sv
// self-checking bench for the microstep wave table driver
`define CHK(a, x) begin nChecks++; if ((a) !== (x)) begin numErrors++; \
  $display("BAD t=%0t got %h exp %h", $time, (a), (x)); end end
module mwt_wave_driver_tb_top
  import mwt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] DUTY = 8'hc8;
  localparam logic [8:0] OFFS = 9'h1f6;
  localparam logic [31:0] TBLX = 32'h6996a55a;
  localparam logic [31:0] SEG = 32'hc0804006;
  localparam logic [7:0] ST0 = 8'h03;
  localparam logic [7:0] ST256 = 8'hfa;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, stepReq, stepDir, stepReady;
  logic commutation_enable_pin, vel, act, lossEn;
  logic [8:0] paddr, curA, curB, sclA, sclB, ofs9;
  logic [31:0] pwdata, prdata, chop, pwmCfg, drvSt, r, smart;
  logic [3:0] pstrb;
  logic [9:0] pos, onTime;
  logic [11:0] lossTime;
  logic [7:0] duty, ofsA, grad;
  logic e;
  int numErrors, nChecks;
  mwt_wave_driver dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .stepReq(stepReq), .stepDir(stepDir),
    .stepReady(stepReady), .commutation_enable_pin(commutation_enable_pin),
    .commutationVelocityReached(vel), .dutyCycleActual(duty), .pwmAutoOffset(ofs9),
    .pwmOfsAuto(ofsA), .pwmGradAuto(grad), .driverStatus(drvSt), .chopperConfig(chop),
    .smartCurrentConfig(smart), .voltagePwmConfig(pwmCfg), .commutationOnTimeCycles(onTime),
    .stepLossOnTimeCycles(lossTime), .stepLossDetectEn(lossEn), .commutationActive(act),
    .microstepPosition(pos), .phaseACurrent(curA), .phaseBCurrent(curB),
    .phaseAScaled(sclA), .phaseBScaled(sclB));
  mwt_stage_model #(.DUTY(DUTY), .OFFS(OFFS)) u_stage (.phaseAScaled(sclA),
    .phaseBScaled(sclB), .dutyCycleActual(duty), .pwmAutoOffset(ofs9), .pwmOfsAuto(ofsA),
    .pwmGradAuto(grad), .driverStatus(drvSt));
  logic [9:0] ep;
  function automatic logic [8:0] wave(input logic [9:0] p);
    int n, v, s;
    logic [31:0] t;
    n = p[8] ? 256 - int'(p[7:0]) : int'(p[7:0]);
    v = (n == 256) ? int'(ST256) : int'(ST0);
    for (int i = 0; i < n && n < 256; i++) begin
      s = int'(i >= int'(SEG[15:8])) + int'(i >= int'(SEG[23:16])) + int'(i >= int'(SEG[31:24]));
      t = TBLX ^ 32'(i / 32);
      v = v + int'(SEG[2*s +: 2]) + int'(t[i % 32]) - 1;
    end
    if (p[9]) v = -v;
    return v[8:0];
  endfunction
  function automatic logic [8:0] scl(input logic [8:0] c);
    logic signed [17:0] m;
    m = $signed(c) * $signed({1'b0, DUTY});
    return m[16:8];
  endfunction
  task automatic endOfTest();
    if (numErrors == 0 && nChecks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [8:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    `CHK(e, 1'b0)
  endtask
  task automatic rdc(input logic [8:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(r, x)
  endtask
  task automatic step(input logic d, input int hold);
    @(posedge ref_clk);
    stepReq <= 1'b1;
    stepDir <= d;
    repeat (hold) @(posedge ref_clk);
    stepReq <= 1'b0;
    ep = d ? ep - 10'h001 : ep + 10'h001;
    do @(negedge ref_clk); while (stepReady !== 1'b1);
    `CHK(pos, ep)
    `CHK(curB, wave(ep))
    `CHK(curA, wave(ep + 10'h100))
    rdc(9'h1a8, {22'h0, ep});
    rdc(9'h1ac, {7'h0, wave(ep + 10'h100), 7'h0, wave(ep)});
    rdc(9'h1bc, {7'h0, scl(wave(ep + 10'h100)), 7'h0, scl(wave(ep))});
    `CHK(sclB, scl(wave(ep)))
  endtask
  task automatic t_reset();
    @(negedge ref_clk);
    `CHK(pwmCfg, PWM_CONFIG_RESET)
    `CHK(curA, 9'h0f7)
    rdc(9'h1b0, CHOPPER_CONFIG_RESET);
    rdc(9'h1ac, 32'h00f70000);
  endtask
  task automatic t_regs();
    wr(9'h1b0, 32'ha5a50f0f);
    wr(9'h1b4, 32'hffffffff);
    wr(9'h1c0, 32'h12345678);
    rdc(9'h1b0, 32'ha5a50f0f);
    `CHK(chop, 32'ha5a50f0f)
    `CHK(smart, 32'h01ffffff)
    `CHK(pwmCfg, 32'h12345678)
    wr(9'h1a8, 32'h00000155);
    rdc(9'h1a8, 32'h0);
    rdc(9'h180, 32'h0);
    apb(1'b1, 9'h1cc, 32'h1);
    `CHK(e, 1'b1)
    apb(1'b0, 9'h1b2, 32'h0);
    `CHK(e, 1'b1)
  endtask
  task automatic t_commut();
    wr(9'h1b8, 32'h00060050);
    @(negedge ref_clk);
    `CHK(onTime, 10'h050)
    `CHK({lossEn, lossTime}, 13'h1060)
    wr(9'h1b8, 32'h00000001);
    @(negedge ref_clk);
    `CHK({lossEn, lossTime, onTime}, 23'h000001)
    rdc(9'h1c4, {7'h0, OFFS, 8'h0, DUTY});
    rdc(9'h1c8, 32'h000e0024);
    commutation_enable_pin <= 1'b1;
    repeat (8) @(posedge ref_clk);
    `CHK(act, 1'b1)
    commutation_enable_pin <= 1'b0;
    repeat (8) @(posedge ref_clk);
    `CHK(act, 1'b0)
    vel <= 1'b1;
    repeat (3) @(posedge ref_clk);
    `CHK(act, 1'b1)
    vel <= 1'b0;
  endtask
  task automatic t_wave();
    // table rewritten at position zero so no half-old wave is walked
    for (int w = 0; w < 8; w++) wr(9'h180 + 9'(4 * w), TBLX ^ 32'(w));
    wr(9'h1a0, SEG);
    wr(9'h1a4, {8'h0, ST256, 8'h0, ST0});
    `CHK(curB, 9'h000)
    ep = 10'h000;
    step(1'b1, 1);
    step(1'b1, 3);
    step(1'b0, 1);
    step(1'b0, 1);
    step(1'b0, 1);
    step(1'b0, 1);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (30000) @(posedge ref_clk);
    numErrors++;
    endOfTest();
  end
  initial begin
    rst_n = 1'b0;
    {psel, penable, pwrite, stepReq, stepDir, commutation_enable_pin, vel} = 7'h00;
    paddr = 9'h000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_regs();
    t_commut();
    t_wave();
    endOfTest();
  end
endmodule // mwt_wave_driver_tb_top

// ### hdl/mwt_pkg.sv
// constants for the microstep wave table driver register bank
package mwt_pkg;

  // register indices; byte address is four times the index
  localparam logic [6:0] IDX_WAVE_TABLE_0   = 7'h60;
  localparam logic [6:0] IDX_WAVE_TABLE_7   = 7'h67;
  localparam logic [6:0] IDX_SEGMENT_SELECT = 7'h68;
  localparam logic [6:0] IDX_START_CURRENTS = 7'h69;
  localparam logic [6:0] IDX_MICROSTEP_POS  = 7'h6a;
  localparam logic [6:0] IDX_PHASE_CURRENT  = 7'h6b;
  localparam logic [6:0] IDX_CHOPPER_CONFIG = 7'h6c;
  localparam logic [6:0] IDX_SMART_CURRENT  = 7'h6d;
  localparam logic [6:0] IDX_COMMUTATION    = 7'h6e;
  localparam logic [6:0] IDX_DRIVER_STATUS  = 7'h6f;
  localparam logic [6:0] IDX_PWM_CONFIG     = 7'h70;
  localparam logic [6:0] IDX_PWM_SCALE      = 7'h71;
  localparam logic [6:0] IDX_PWM_AUTOTUNE   = 7'h72;

  // table geometry
  localparam int TABLE_WORDS    = 8;
  localparam int TABLE_ENTRIES  = 256;
  localparam logic [9:0] PHASE_A_OFFSET = 10'h100;

  // segment select field positions
  localparam int SEG_W0_LSB = 0;
  localparam int SEG_W1_LSB = 2;
  localparam int SEG_W2_LSB = 4;
  localparam int SEG_W3_LSB = 6;
  localparam int SEG_X1_LSB = 8;
  localparam int SEG_X2_LSB = 16;
  localparam int SEG_X3_LSB = 24;

  // start current fields and their reset values
  localparam int START_ENTRY0_LSB   = 0;
  localparam int START_ENTRY256_LSB = 16;
  localparam logic [7:0] ENTRY0_START_RESET   = 8'h00;
  localparam logic [7:0] ENTRY256_START_RESET = 8'hf7;

  // readback field positions
  localparam int CURRENT_B_LSB  = 0;
  localparam int CURRENT_A_LSB  = 16;
  localparam int PWM_DUTY_LSB   = 0;
  localparam int PWM_OFFSET_LSB = 16;
  localparam int PWM_OFS_LSB    = 0;
  localparam int PWM_GRADIENT_SETTING_LSB   = 16;

  // commutation control fields; on-time units in clock periods
  localparam int COMMUT_TIME_LSB   = 0;
  localparam int STEP_LOSS_LSB     = 16;
  localparam int COMMUT_TIME_UNIT  = 1;
  localparam int STEP_LOSS_UNIT    = 16;

  // reset values of configuration registers
  localparam logic [31:0] CHOPPER_CONFIG_RESET = 32'h10410150;
  localparam logic [31:0] PWM_CONFIG_RESET     = 32'hc40c001e;
  localparam logic [31:0] ZERO_RESET           = 32'h00000000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_WALK = 2'b10
  } mwt_state_t;

endpackage

// ### hdl/mwt_wave_driver.sv
// microstep wave table driver register bank with APB slave
// Operation
// RULE_01 - table bit codes step between entries
// RULE_02 - bit one adds width code, zero one less
// RULE_03 - eight write-only words hold quarter wave
// RULE_04 - word bit 0 is lowest entry
// RULE_05 - four segments each with 2-bit code
// RULE_06 - segment ranges set by three borders
// RULE_07 - software keeps borders increasing, above zero
// RULE_08 - start register holds entry 0, 256 currents
// RULE_09 - passing zero loads both start currents
// RULE_10 - start currents reset to 0 and 247
// RULE_11 - 10-bit read-only microstep position for B
// RULE_12 - phase A position is B plus 256
// RULE_13 - software rewrites table only at zero
// RULE_14 - readback gives signed 9-bit B and A
// RULE_15 - chopper config resets to fixed value
// RULE_16 - commutation on-time limit in clock periods
// RULE_17 - step-loss limit in 16 clocks, zero disables
// RULE_18 - commutation enabled by pin or velocity
// RULE_19 - software sets sensible on-time limits
// RULE_20 - voltage PWM config resets to fixed value
// RULE_21 - duty cycle readback scales both currents
// RULE_22 - signed regulator offset readback, bits 24:16
// RULE_23 - autotune offset readback in bits 7:0
// RULE_24 - full wave by mirroring and negating
//
// Our own choice: the APB register port.
module mwt_wave_driver
  import mwt_pkg::*;
#(
  parameter logic [31:0] TABLE_INIT   [TABLE_WORDS] = '{default: 32'h00000000},
  parameter logic [31:0] SEGMENT_INIT = 32'h00000000
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [8:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // step request from motion logic
  input  wire logic        stepReq,
  input  wire logic        stepDir,
  output logic             stepReady,
  // commutation enables
  input  wire logic        commutation_enable_pin,
  input  wire logic        commutationVelocityReached,
  // regulator and status inputs
  input  wire logic [7:0]  dutyCycleActual,
  input  wire logic [8:0]  pwmAutoOffset,
  input  wire logic [7:0]  pwmOfsAuto,
  input  wire logic [7:0]  pwmGradAuto,
  input  wire logic [31:0] driverStatus,
  // outputs to chopper and power stage
  output logic [31:0]      chopperConfig,
  output logic [31:0]      smartCurrentConfig,
  output logic [31:0]      voltagePwmConfig,
  output logic [9:0]       commutationOnTimeCycles,
  output logic [11:0]      stepLossOnTimeCycles,
  output logic             stepLossDetectEn,
  output logic             commutationActive,
  output logic [9:0]       microstepPosition,
  output logic [8:0]       phaseACurrent,
  output logic [8:0]       phaseBCurrent,
  output logic [8:0]       phaseAScaled,
  output logic [8:0]       phaseBScaled
);

  // byte-lane merge for apb writes
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction

  // step between entry idx and idx+1
  function automatic logic signed [2:0] lutDelta(input logic [7:0] idx, input logic tbit,
                                                 input logic [31:0] seg);
    logic [1:0] w;
    w = seg[SEG_W0_LSB +: 2];
    // RULE_06 segment by borders
    if (idx >= seg[SEG_X3_LSB +: 8]) begin
      w = seg[SEG_W3_LSB +: 2];
    end else if (idx >= seg[SEG_X2_LSB +: 8]) begin
      w = seg[SEG_W2_LSB +: 2];
    end else if (idx >= seg[SEG_X1_LSB +: 8]) begin
      w = seg[SEG_W1_LSB +: 2];
    end
    // RULE_02 bit adds width code, minus one for zero
    return $signed({1'b0, w}) + $signed({2'b00, tbit}) - 3'sd1;
  endfunction

  // walk length within the quarter table; odd quarters mirror the index
  function automatic logic [8:0] walkLen(input logic [9:0] pos);
    logic [8:0] n;
    n = {1'b0, pos[7:0]};
    // RULE_24 mirror index in odd quarters
    if (pos[8]) begin
      n = 9'h100 - {1'b0, pos[7:0]};
    end
    return n;
  endfunction

  // apb decode
  logic [6:0]  regIdx;
  logic        aligned;
  logic        setupPhase;
  logic        writeDone;
  logic        mapped;
  logic [31:0] readValue;

  assign regIdx     = paddr[8:2];
  assign aligned    = (paddr[1:0] == 2'b00);
  assign setupPhase = psel && !penable;
  assign pready     = 1'b1;
  assign writeDone  = psel && penable && pwrite && !pslverr;

  // registers
  logic [31:0] tableWord_q [TABLE_WORDS];
  logic [31:0] segmentSelect_q;
  logic [7:0]  entry0Start_q;
  logic [7:0]  entry256Start_q;
  logic [31:0] chopperConfig_q;
  logic [31:0] smartCurrent_q;
  logic [23:0] commutation_q;
  logic [31:0] pwmConfig_q;

  // RULE_03 eight table words, write only
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < TABLE_WORDS; i++) begin
      if (!rst_n) begin
        tableWord_q[i] <= TABLE_INIT[i];
      end else if (writeDone && regIdx == IDX_WAVE_TABLE_0 + 7'(i)) begin
        tableWord_q[i] <= laneMerge(tableWord_q[i], pwdata, pstrb);
      end
    end
  end

  // RULE_05 segment select register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      segmentSelect_q <= SEGMENT_INIT;
    end else if (writeDone && regIdx == IDX_SEGMENT_SELECT) begin
      segmentSelect_q <= laneMerge(segmentSelect_q, pwdata, pstrb);
    end
  end

  // RULE_08 start currents; RULE_10 reset values
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      entry0Start_q   <= ENTRY0_START_RESET;
      entry256Start_q <= ENTRY256_START_RESET;
    end else if (writeDone && regIdx == IDX_START_CURRENTS) begin
      if (pstrb[START_ENTRY0_LSB / 8]) begin
        entry0Start_q <= pwdata[START_ENTRY0_LSB +: 8];
      end
      if (pstrb[START_ENTRY256_LSB / 8]) begin
        entry256Start_q <= pwdata[START_ENTRY256_LSB +: 8];
      end
    end
  end

  // RULE_15 chopper config reset; RULE_20 pwm config reset
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      chopperConfig_q <= CHOPPER_CONFIG_RESET;
      smartCurrent_q  <= ZERO_RESET;
      commutation_q   <= ZERO_RESET[23:0];
      pwmConfig_q     <= PWM_CONFIG_RESET;
    end else if (writeDone) begin
      if (regIdx == IDX_CHOPPER_CONFIG) begin
        chopperConfig_q <= laneMerge(chopperConfig_q, pwdata, pstrb);
      end
      if (regIdx == IDX_SMART_CURRENT) begin
        smartCurrent_q <= laneMerge(smartCurrent_q, pwdata, pstrb) & 32'h01ffffff;
      end
      if (regIdx == IDX_COMMUTATION) begin
        commutation_q <= 24'(laneMerge({8'h00, commutation_q}, pwdata, pstrb));
      end
      if (regIdx == IDX_PWM_CONFIG) begin
        pwmConfig_q <= laneMerge(pwmConfig_q, pwdata, pstrb);
      end
    end
  end

  // microstep position and walker
  mwt_state_t   state_q;
  logic [9:0]   position_q;
  logic [7:0]   walkIdx_q;
  logic [8:0]   lenB_q;
  logic [8:0]   lenA_q;
  logic [8:0]   lenMax;
  logic [9:0]   quadB_q;
  logic [9:0]   quadA_q;
  logic signed [10:0] accB_q;
  logic signed [10:0] accA_q;
  logic signed [8:0]  curA_q;
  logic signed [8:0]  curB_q;
  logic [9:0]   nextPos;
  logic [9:0]   nextPosA;
  logic         stepTake;
  logic         tableBit;
  logic signed [2:0] delta;

  assign stepReady = (state_q == ST_IDLE);
  assign stepTake  = stepReq && stepReady;
  // RULE_11 position moves one microstep per accepted step
  assign nextPos   = stepDir ? position_q - 10'd1 : position_q + 10'd1;
  // RULE_12 phase A offset
  assign nextPosA  = nextPos + PHASE_A_OFFSET;
  assign lenMax    = (lenA_q > lenB_q) ? lenA_q : lenB_q;
  // RULE_04 bit 0 of a word is its lowest entry
  assign tableBit  = tableWord_q[walkIdx_q[7:5]][walkIdx_q[4:0]];
  // RULE_01 each bit codes the step to the next entry
  assign delta     = lutDelta(walkIdx_q, tableBit, segmentSelect_q);

  // signed phase value from a walked magnitude
  function automatic logic signed [8:0] phaseValue(input logic [9:0] pos,
                                                   input logic signed [10:0] acc,
                                                   input logic [7:0] s256);
    logic signed [10:0] mag;
    mag = acc;
    if (pos[8] && pos[7:0] == 8'h00) begin
      mag = $signed({3'b000, s256});
    end
    // RULE_24 negate second half
    if (pos[9]) begin
      mag = -mag;
    end
    return mag[8:0];
  endfunction

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q    <= ST_IDLE;
      position_q <= 10'h000;
      walkIdx_q  <= 8'h00;
      lenB_q     <= 9'h000;
      lenA_q     <= 9'h000;
      quadB_q    <= 10'h000;
      quadA_q    <= PHASE_A_OFFSET;
      accB_q     <= 11'sd0;
      accA_q     <= 11'sd0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (stepTake) begin
            position_q <= nextPos;
            // RULE_09 zero crossing bypasses the walk
            if (nextPos != 10'h000) begin
              state_q <= ST_WALK;
            end
            walkIdx_q <= 8'h00;
            quadB_q   <= nextPos;
            quadA_q   <= nextPosA;
            lenB_q    <= walkLen(nextPos);
            lenA_q    <= walkLen(nextPosA);
            accB_q    <= $signed({3'b000, entry0Start_q});
            accA_q    <= $signed({3'b000, entry0Start_q});
          end
        end
        ST_WALK: begin
          // entry 256 comes from its start value, so walks stop at 255
          if ({1'b0, walkIdx_q} == lenMax || walkIdx_q == 8'hff) begin
            state_q <= ST_IDLE;
          end else begin
            walkIdx_q <= walkIdx_q + 8'd1;
            if ({1'b0, walkIdx_q} < lenB_q) begin
              accB_q <= accB_q + 11'(delta);
            end
            if ({1'b0, walkIdx_q} < lenA_q) begin
              accA_q <= accA_q + 11'(delta);
            end
          end
        end
      endcase
    end
  end

  // current registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      curB_q <= $signed({1'b0, ENTRY0_START_RESET});
      curA_q <= $signed({1'b0, ENTRY256_START_RESET});
    end else if (stepTake && nextPos == 10'h000) begin
      // RULE_09 load start currents at zero
      curB_q <= $signed({1'b0, entry0Start_q});
      curA_q <= $signed({1'b0, entry256Start_q});
    end else if (state_q == ST_WALK &&
                 ({1'b0, walkIdx_q} == lenMax || walkIdx_q == 8'hff)) begin
      curB_q <= phaseValue(quadB_q, accB_q, entry256Start_q);
      curA_q <= phaseValue(quadA_q, accA_q, entry256Start_q);
    end
  end

  // RULE_21 scale both phases by the duty cycle
  logic signed [17:0] prodA;
  logic signed [17:0] prodB;
  assign prodA = curA_q * $signed({1'b0, dutyCycleActual});
  assign prodB = curB_q * $signed({1'b0, dutyCycleActual});

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      phaseAScaled <= 9'h000;
      phaseBScaled <= 9'h000;
    end else begin
      phaseAScaled <= prodA[16:8];
      phaseBScaled <= prodB[16:8];
    end
  end

  // pin synchroniser; a change counts once stages two and three agree
  logic pinSync1_q;
  logic pinSync2_q;
  logic pinSync3_q;
  logic pinLevel_q;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pinSync1_q <= 1'b0;
      pinSync2_q <= 1'b0;
      pinSync3_q <= 1'b0;
      pinLevel_q <= 1'b0;
    end else begin
      pinSync1_q <= commutation_enable_pin;
      pinSync2_q <= pinSync1_q;
      pinSync3_q <= pinSync2_q;
      if (pinSync2_q == pinSync3_q) begin
        pinLevel_q <= pinSync3_q;
      end
    end
  end

  // RULE_18 pin or velocity threshold enables commutation
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      commutationActive <= 1'b0;
    end else begin
      commutationActive <= pinLevel_q || commutationVelocityReached;
    end
  end

  // RULE_16 on-time limit in clock periods
  assign commutationOnTimeCycles = 10'(commutation_q[COMMUT_TIME_LSB +: 10] * COMMUT_TIME_UNIT);
  // RULE_17 step-loss limit in 16-clock units, zero disables
  assign stepLossOnTimeCycles = 12'(commutation_q[STEP_LOSS_LSB +: 8] * STEP_LOSS_UNIT);
  assign stepLossDetectEn     = (commutation_q[STEP_LOSS_LSB +: 8] != 8'h00);

  assign chopperConfig      = chopperConfig_q;
  assign smartCurrentConfig = smartCurrent_q;
  assign voltagePwmConfig   = pwmConfig_q;
  assign microstepPosition  = position_q;
  assign phaseACurrent      = curA_q;
  assign phaseBCurrent      = curB_q;

  // read mux; write-only registers read as zero
  always_comb begin
    readValue = 32'h00000000;
    mapped    = 1'b1;
    if (regIdx >= IDX_WAVE_TABLE_0 && regIdx <= IDX_WAVE_TABLE_7) begin
      readValue = 32'h00000000;
    end else begin
      unique case (regIdx)
        IDX_SEGMENT_SELECT, IDX_START_CURRENTS, IDX_SMART_CURRENT,
        IDX_COMMUTATION, IDX_PWM_CONFIG: readValue = 32'h00000000;
        // RULE_11 position readback
        IDX_MICROSTEP_POS:  readValue = {22'h0, position_q};
        // RULE_14 signed currents, B low and A high
        IDX_PHASE_CURRENT:  readValue = {7'h00, curA_q, 7'h00, curB_q};
        IDX_CHOPPER_CONFIG: readValue = chopperConfig_q;
        IDX_DRIVER_STATUS:  readValue = driverStatus;
        // RULE_22 regulator offset beside RULE_21 duty
        IDX_PWM_SCALE:      readValue = {7'h00, pwmAutoOffset, 8'h00, dutyCycleActual};
        // RULE_23 autotune offset and gradient
        IDX_PWM_AUTOTUNE:   readValue = {8'h00, pwmGradAuto, 8'h00, pwmOfsAuto};
        default:            mapped = 1'b0;
      endcase
    end
  end

  // answer prepared in setup so the access phase completes at once
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      prdata  <= pwrite ? 32'h00000000 : readValue;
      pslverr <= !(mapped && aligned);
    end
  end

endmodule // mwt_wave_driver
